// [verilog/btc_pkg.sv]
/*
 Package for the time-of-day counter block: register offsets, field
 positions, reset values and BCD limits.
 Assumes a single 40 MHz clock domain and an external register port.
*/
`default_nettype none
package btc_pkg;
   // Register offsets
   localparam logic [7:0] BTC_OFF_SEC  = 8'h03;
   localparam logic [7:0] BTC_OFF_MIN  = 8'h04;
   localparam logic [7:0] BTC_OFF_HOUR = 8'h05;
   localparam logic [7:0] BTC_OFF_DAY  = 8'h06;
   localparam logic [7:0] BTC_OFF_WDAY = 8'h07;
   // Field positions
   localparam int BTC_OSF_BIT  = 7;
   localparam int BTC_HALF_BIT = 5;
   // Implemented-bit masks per register
   localparam logic [7:0] BTC_MASK_SEC  = 8'h7F;
   localparam logic [7:0] BTC_MASK_MIN  = 8'h7F;
   localparam logic [7:0] BTC_MASK_H12  = 8'h1F;
   localparam logic [7:0] BTC_MASK_H24  = 8'h3F;
   localparam logic [7:0] BTC_MASK_DAY  = 8'h3F;
   localparam logic [7:0] BTC_MASK_WDAY = 8'h07;
   // Reset values of control state
   localparam logic       BTC_OSF_RST  = 1'b1;
   localparam logic       BTC_MODE_RST = 1'b0;   // 0 selects 24-hour
   // BCD limits
   localparam logic [7:0] BTC_BCD_59   = 8'h59;
   localparam logic [7:0] BTC_BCD_23   = 8'h23;
   localparam logic [7:0] BTC_BCD_12   = 8'h12;
   localparam logic [7:0] BTC_BCD_11   = 8'h11;
   localparam logic [7:0] BTC_BCD_01   = 8'h01;
   localparam logic [2:0] BTC_WDAY_MAX = 3'h6;
   localparam logic [4:0] BTC_MONTH_FEB = 5'h02;
endpackage
`default_nettype wire

// [verilog/btc_bcd_if.sv]
/*
 Interface carrying one BCD digit pair into the increment module
 and its result back out.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface btc_bcd_if;
   logic [7:0] val;     // Current BCD value
   logic [7:0] lo;      // Value after wrap
   logic [7:0] hi;      // Last value before wrap
   logic [7:0] res;     // Next value
   logic       wrap;    // Value was at hi
   modport user (output val, output lo, output hi, input res, input wrap);
   modport incr (input val, input lo, input hi, output res, output wrap);
endinterface
`default_nettype wire

// [verilog/btc_bcd_inc.sv]
/*
 Combinational BCD incrementer with wrap from a given high value to a
 given low value.
 Assumes well-formed BCD input; an illegal units digit carries into the tens as 9 does.
*/
`timescale 1ns/1ps
`default_nettype none
module btc_bcd_inc (
   // Digit pair
   btc_bcd_if.incr b
);
   // Step units, carry into tens
   always_comb begin
      b.wrap = (b.val == b.hi);
      if (b.wrap) begin
         b.res = b.lo;
      end else if (b.val[3:0] >= 4'h9) begin
         b.res = {b.val[7:4] + 4'h1, 4'h0};
      end else begin
         b.res = {b.val[7:4], b.val[3:0] + 4'h1};
      end
   end
endmodule
`default_nettype wire

// [verilog/btc_time_counters.sv]
/*
 Seconds, minutes, hours, day-of-month and weekday counters in BCD with
 host register access and a frozen update while the host is busy.
 Assumes the host port, 1 Hz tick, oscillator-stop level, year and month
 come from logic on the same clock.
*/
// Function
// - bit 7 of seconds is the oscillator stop flag, 1 means integrity lost
// - seconds 00 to 59 BCD, tens in 6:4, units in 3:0
// - minutes 00 to 59 BCD, tens in 6:4, units in 3:0
// - unimplemented bits store nothing and read zero
// - time counters have no reset value and keep contents through reset
// - 12-hour mode counts 1 to 12, tens is bit 4
// - in 12-hour mode bit 5 of hours is PM when set
// - 24-hour mode counts 0 to 23, tens in bits 5:4
// - hour-format input selects 12 or 24 hour counting and encoding
// - day of month 1 to 31 BCD, tens in bits 5:4
// - year divisible by 4, including 00, gives February 29 days
// - weekday 0 to 6 in bits 2:0, wraps 6 to 0 each day
// - oscillator stop or internal reset sets the flag, kept after reset
// - flag clears only when the host writes 0 to it
// - counters frozen during host access, one pending tick applied after
// - hour format defaults to 24-hour after reset
`timescale 1ns/1ps
`default_nettype none
module btc_time_counters (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // Host register port
   input  wire logic       host_busy,
   input  wire logic       wr_en,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   output var  logic [7:0] rdata,
   // Control and status
   input  wire logic       tick_1hz,
   input  wire logic       osc_stop,
   input  wire logic       fmt12_wr,
   input  wire logic       fmt12_val,
   output var  logic       fmt12,
   // Calendar links
   input  wire logic [7:0] year_bcd,
   input  wire logic [4:0] month_bcd,
   output var  logic       month_carry
);
   import btc_pkg::*;

   logic [6:0] sec_r,  sec_nxt;
   logic [6:0] min_r,  min_nxt;
   logic [5:0] hour_r, hour_nxt;
   logic [5:0] day_r,  day_nxt;
   logic [2:0] wday_r, wday_nxt;
   logic       osf_r,  osf_nxt;
   logic       fmt_r,  fmt_nxt;
   logic       pend_r, pend_nxt;
   logic [7:0] rd_r,   rd_nxt;
   logic       mc_r,   mc_nxt;
   logic       step;
   logic [7:0] last_day;

   btc_bcd_if s_if();
   btc_bcd_if m_if();
   btc_bcd_if h_if();
   btc_bcd_if d_if();
   btc_bcd_inc u_sec  (.b(s_if));
   btc_bcd_inc u_min  (.b(m_if));
   btc_bcd_inc u_hour (.b(h_if));
   btc_bcd_inc u_day  (.b(d_if));

   // Leap test on BCD year: tens even needs units 0,4,8; odd needs 2,6
   function automatic logic is_leap(input logic [7:0] y);
      is_leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                     : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
   endfunction

   // Month length in BCD
   always_comb begin
      case (month_bcd)
         5'h02:                        last_day = is_leap(year_bcd) ? 8'h29 : 8'h28;
         5'h04, 5'h06, 5'h09, 5'h11:   last_day = 8'h30;
         default:                      last_day = 8'h31;
      endcase
   end

   // Increment inputs for each digit pair
   always_comb begin
      s_if.val = {1'b0, sec_r};
      s_if.lo  = 8'h00;
      s_if.hi  = BTC_BCD_59;
      m_if.val = {1'b0, min_r};
      m_if.lo  = 8'h00;
      m_if.hi  = BTC_BCD_59;
      d_if.val = {2'b00, day_r};
      d_if.lo  = BTC_BCD_01;
      d_if.hi  = last_day;
      if (fmt_r) begin
         h_if.val = {3'b000, hour_r[4:0]};
         h_if.lo  = BTC_BCD_01;
         h_if.hi  = BTC_BCD_12;
      end else begin
         h_if.val = {2'b00, hour_r};
         h_if.lo  = 8'h00;
         h_if.hi  = BTC_BCD_23;
      end
   end

   // Tick is applied only outside host access; one tick is held pending
   assign step = !host_busy && (tick_1hz || pend_r);

   // Next values for counters, flags and read data
   always_comb begin
      logic sec_w;
      logic min_w;
      logic day_adv;
      sec_w    = 1'b0;
      min_w    = 1'b0;
      day_adv  = 1'b0;
      sec_nxt  = sec_r;
      min_nxt  = min_r;
      hour_nxt = hour_r;
      day_nxt  = day_r;
      wday_nxt = wday_r;
      osf_nxt  = osf_r;
      fmt_nxt  = fmt_r;
      mc_nxt   = 1'b0;
      pend_nxt = pend_r;
      // Pending store: at most one tick remembered while frozen
      if (host_busy && tick_1hz) begin
         pend_nxt = 1'b1;
      end else if (step) begin
         // A fresh tick in the cycle that drains the held one is kept, not lost
         pend_nxt = pend_r && tick_1hz;
      end
      if (fmt12_wr) begin
         fmt_nxt = fmt12_val;
      end
      // Counting chain
      if (step) begin
         sec_nxt = s_if.res[6:0];
         sec_w   = s_if.wrap;
         if (sec_w) begin
            min_nxt = m_if.res[6:0];
            min_w   = m_if.wrap;
         end
         if (sec_w && min_w) begin
            if (fmt_r) begin
               hour_nxt[4:0] = h_if.res[4:0];
               if (hour_r[4:0] == BTC_BCD_11[4:0]) begin
                  hour_nxt[BTC_HALF_BIT] = !hour_r[BTC_HALF_BIT];
                  day_adv = hour_r[BTC_HALF_BIT];
               end
            end else begin
               hour_nxt = h_if.res[5:0];
               day_adv  = h_if.wrap;
            end
         end
         if (day_adv) begin
            day_nxt  = d_if.res[5:0];
            mc_nxt   = d_if.wrap;
            wday_nxt = (wday_r == BTC_WDAY_MAX) ? 3'h0 : wday_r + 3'h1;
         end
      end
      // Host writes override counting; field slices of wdata drop unimplemented bits
      if (wr_en) begin
         if (addr == BTC_OFF_SEC) begin
            sec_nxt = wdata[6:0];
            if (!wdata[BTC_OSF_BIT]) begin
               osf_nxt = 1'b0;
            end
         end else if (addr == BTC_OFF_MIN) begin
            min_nxt = wdata[6:0];
         end else if (addr == BTC_OFF_HOUR) begin
            hour_nxt = wdata[5:0];
         end else if (addr == BTC_OFF_DAY) begin
            day_nxt = wdata[5:0];
         end else if (addr == BTC_OFF_WDAY) begin
            wday_nxt = wdata[2:0];
         end
      end
      // Oscillator stop wins over a host clear
      if (osc_stop) begin
         osf_nxt = 1'b1;
      end
      // Read mux, unimplemented bits as zero
      if (addr == BTC_OFF_SEC) begin
         rd_nxt = {osf_r, sec_r};
      end else if (addr == BTC_OFF_MIN) begin
         rd_nxt = {1'b0, min_r} & BTC_MASK_MIN;
      end else if (addr == BTC_OFF_HOUR) begin
         // Both formats store bits 5:0; in 12-hour mode bit 5 is half-day
         rd_nxt = {2'b00, hour_r} & BTC_MASK_H24;
      end else if (addr == BTC_OFF_DAY) begin
         rd_nxt = {2'b00, day_r} & BTC_MASK_DAY;
      end else if (addr == BTC_OFF_WDAY) begin
         rd_nxt = {5'b00000, wday_r} & BTC_MASK_WDAY;
      end else begin
         rd_nxt = 8'h00;
      end
   end

   // Counters are never reset so that their contents survive reset
   always_ff @(posedge clk) begin
      sec_r  <= sec_nxt;
      min_r  <= min_nxt;
      hour_r <= hour_nxt;
      day_r  <= day_nxt;
      wday_r <= wday_nxt;
   end

   // Control state with synchronous reset; reset itself raises the flag
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         osf_r  <= BTC_OSF_RST;
         fmt_r  <= BTC_MODE_RST;
         pend_r <= 1'b0;
         rd_r   <= 8'h00;
         mc_r   <= 1'b0;
      end else begin
         osf_r  <= osf_nxt;
         fmt_r  <= fmt_nxt;
         pend_r <= pend_nxt;
         rd_r   <= rd_nxt;
         mc_r   <= mc_nxt;
      end
   end

   assign rdata       = rd_r;
   assign fmt12       = fmt_r;
   assign month_carry = mc_r;

   // Checks
   osf_set_a: assert property (@(posedge clk) disable iff (!rst_b)
      osc_stop |=> osf_r) else $error("stop flag not set");
   osf_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
      (osf_r && !(wr_en && addr == BTC_OFF_SEC && !wdata[7])) |=> osf_r)
      else $error("stop flag lost");
   freeze_a: assert property (@(posedge clk) disable iff (!rst_b)
      (host_busy && !wr_en) |=> $stable(sec_r)) else $error("count while busy");
   pend_a: assert property (@(posedge clk) disable iff (!rst_b)
      (host_busy && tick_1hz) |=> pend_r) else $error("tick not held");
   sec_wrap_a: assert property (@(posedge clk) disable iff (!rst_b)
      (step && !wr_en && sec_r == 7'h59) |=> sec_r == 7'h00) else $error("sec wrap");
   wday_wrap_a: assert property (@(posedge clk) disable iff (!rst_b)
      (day_nxt != day_r && !wr_en && wday_r == 3'h6) |=> wday_r == 3'h0)
      else $error("weekday wrap");
   mcarry_a: assert property (@(posedge clk) disable iff (!rst_b)
      month_carry |-> day_r == 6'h01) else $error("carry without day 1");
   h24_wrap_a: assert property (@(posedge clk) disable iff (!rst_b)
      (step && !wr_en && !fmt_r && sec_r == 7'h59 && min_r == 7'h59
       && hour_r == 6'h23) |=> hour_r == 6'h00) else $error("24h wrap");
   h12_wrap_a: assert property (@(posedge clk) disable iff (!rst_b)
      (step && !wr_en && fmt_r && sec_r == 7'h59 && min_r == 7'h59
       && hour_r[4:0] == 5'h12) |=> hour_r[4:0] == 5'h01) else $error("12h wrap");
   rd_mask_a: assert property (@(posedge clk) disable iff (!rst_b)
      $past(addr) == BTC_OFF_WDAY |-> rdata[7:3] == 5'h00) else $error("wday mask");
   cov_mcarry: cover property (@(posedge clk) month_carry);
   cov_pend: cover property (@(posedge clk) pend_r && !host_busy);
   cov_half: cover property (@(posedge clk) fmt_r && $rose(hour_r[5]));
endmodule
`default_nettype wire

// [verification/btc_tick_model.sv]
/*
 Model of the 1 Hz tick source that feeds the time counters.
 Assumes the bench requests each tick with a one-cycle pulse on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module btc_tick_model (
   // Clock and request
   input  wire logic clk,
   input  wire logic fire,
   // Tick out
   output var  logic tick_1hz
);
   // Quiet at time zero so the counters never see an unknown tick
   initial tick_1hz = 1'b0;
   // One clean pulse per request; a held request would give a stretched tick
   always @(posedge clk) begin
      tick_1hz <= fire;
   end
endmodule
`default_nettype wire

// [verification/tb_top.sv]
/*
 Self-checking bench for the time-of-day counters.
 Assumes a write is taken on an edge with wr_en high and read data is
 registered one edge after the address.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import btc_pkg::*;
   logic       clk = 1'b0;
   logic       rst_b = 1'b0;
   logic       host_busy = 1'b0;
   logic       wr_en = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic       fire = 1'b0;
   logic       tick_1hz;
   logic       osc_stop = 1'b0;
   logic       fmt12_wr = 1'b0;
   logic       fmt12_val = 1'b0;
   logic       fmt12;
   logic [7:0] year_bcd = 8'h23;
   logic [4:0] month_bcd = 5'h02;
   logic       month_carry;
   logic       mc;
   int         mismatches = 0;
   int         num_checks = 0;

   // 40 MHz clock
   always #12.5 clk = ~clk;

   btc_tick_model btc_tick_model_inst (.clk(clk), .fire(fire), .tick_1hz(tick_1hz));
   btc_time_counters btc_time_counters_inst (
      .clk(clk), .rst_b(rst_b), .host_busy(host_busy), .wr_en(wr_en),
      .addr(addr), .wdata(wdata), .rdata(rdata), .tick_1hz(tick_1hz),
      .osc_stop(osc_stop), .fmt12_wr(fmt12_wr), .fmt12_val(fmt12_val),
      .fmt12(fmt12), .year_bcd(year_bcd), .month_bcd(month_bcd),
      .month_carry(month_carry));

   // Verdict in one place only
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic do_reset();
      rst_b <= 1'b0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   // Address on one edge, registered data settled after the next
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      @(posedge clk);
      #1 chk(rdata, exp);
   endtask

   // Tick request; month carry is caught over a bounded window
   task automatic tick();
      mc = 1'b0;
      @(posedge clk);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         #1 if (month_carry === 1'b1) mc = 1'b1;
      end
   endtask

   task automatic set_time(input logic [7:0] h, input logic [7:0] d);
      wr(BTC_OFF_SEC, 8'h59);
      wr(BTC_OFF_MIN, 8'h59);
      wr(BTC_OFF_HOUR, h);
      wr(BTC_OFF_DAY, d);
      wr(BTC_OFF_WDAY, 8'h06);
   endtask

   // Full carry chain from 59:59; weekday wraps only when the day moves
   task automatic roll(input logic [7:0] h, input logic [7:0] d,
                       input logic [7:0] he, input logic [7:0] de);
      set_time(h, d);
      tick();
      rdc(BTC_OFF_SEC, 8'h00);
      rdc(BTC_OFF_MIN, 8'h00);
      rdc(BTC_OFF_HOUR, he);
      rdc(BTC_OFF_DAY, de);
      rdc(BTC_OFF_WDAY, (de !== d) ? 8'h00 : 8'h06);
      chk({7'h00, mc}, {7'h00, de === 8'h01});
   endtask

   initial begin
      do_reset();
      #1 chk({7'h00, fmt12}, 8'h00);
      rdc(8'h02, 8'h00);
      wr(BTC_OFF_SEC, 8'h00);
      rdc(BTC_OFF_SEC, 8'h00);
      // Unimplemented bits are dropped on write
      wr(BTC_OFF_MIN, 8'hC5);
      rdc(BTC_OFF_MIN, 8'h45);
      wr(BTC_OFF_WDAY, 8'hFD);
      rdc(BTC_OFF_WDAY, 8'h05);
      // 24-hour rollover and month ends, leap years included
      @(posedge clk);
      year_bcd <= 8'h23;
      roll(8'h23, 8'h28, 8'h00, 8'h01);
      @(posedge clk);
      year_bcd <= 8'h24;
      roll(8'h23, 8'h28, 8'h00, 8'h29);
      roll(8'h23, 8'h29, 8'h00, 8'h01);
      @(posedge clk);
      year_bcd <= 8'h00;
      roll(8'h23, 8'h28, 8'h00, 8'h29);
      roll(8'h09, 8'h10, 8'h10, 8'h10);
      // Thirty-day month with a two-digit BCD code, then a 31-day month
      @(posedge clk);
      month_bcd <= 5'h11;
      roll(8'h23, 8'h30, 8'h00, 8'h01);
      @(posedge clk);
      month_bcd <= 5'h01;
      roll(8'h23, 8'h30, 8'h00, 8'h31);
      roll(8'h23, 8'h31, 8'h00, 8'h01);
      // 12-hour sequence through noon and midnight
      @(posedge clk);
      fmt12_wr  <= 1'b1;
      fmt12_val <= 1'b1;
      @(posedge clk);
      fmt12_wr <= 1'b0;
      #1 chk({7'h00, fmt12}, 8'h01);
      roll(8'h11, 8'h10, 8'h32, 8'h10);
      roll(8'h32, 8'h10, 8'h21, 8'h10);
      roll(8'h31, 8'h10, 8'h12, 8'h11);
      // Ticks while busy are held, only one is kept
      wr(BTC_OFF_SEC, 8'h10);
      host_busy <= 1'b1;
      tick();
      tick();
      rdc(BTC_OFF_SEC, 8'h10);
      @(posedge clk);
      host_busy <= 1'b0;
      repeat (3) @(posedge clk);
      rdc(BTC_OFF_SEC, 8'h11);
      // Stop flag: set beats a clearing write, a 1 write leaves it
      @(posedge clk);
      osc_stop <= 1'b1;
      wr(BTC_OFF_SEC, 8'h00);
      rdc(BTC_OFF_SEC, 8'h80);
      @(posedge clk);
      osc_stop <= 1'b0;
      wr(BTC_OFF_SEC, 8'h80);
      rdc(BTC_OFF_SEC, 8'h80);
      wr(BTC_OFF_SEC, 8'h00);
      rdc(BTC_OFF_SEC, 8'h00);
      // Counters survive a reset, flag and format do not
      wr(BTC_OFF_MIN, 8'h37);
      do_reset();
      rdc(BTC_OFF_MIN, 8'h37);
      rdc(BTC_OFF_SEC, 8'h80);
      chk({7'h00, fmt12}, 8'h00);
      stop_test();
   end
endmodule
`default_nettype wire
